// file: frtc_pkg.sv
package frtc_pkg;

   // ------------------------------------------------------------
   // register offsets (byte-wide register file)
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_CTRL1     = 4'h0;
   localparam logic [3:0] OFF_CTRL2     = 4'h1;
   localparam logic [3:0] OFF_STATUS    = 4'h2;
   localparam logic [3:0] OFF_CAP1_HI   = 4'h3;
   localparam logic [3:0] OFF_CAP1_LO   = 4'h4;
   localparam logic [3:0] OFF_CAP2_HI   = 4'h5;
   localparam logic [3:0] OFF_CAP2_LO   = 4'h6;
   localparam logic [3:0] OFF_CNT_HI    = 4'h8;
   localparam logic [3:0] OFF_CNT_LO    = 4'h9;
   localparam logic [3:0] OFF_ALT_HI    = 4'ha;
   localparam logic [3:0] OFF_ALT_LO    = 4'hb;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   // control one
   localparam int CTRL1_CAP_IRQ_EN  = 7;
   localparam int CTRL1_OVF_IRQ_EN  = 5;
   localparam int CTRL1_CAP1_EDGE   = 1;
   // control two, except CTRL2_PWM, which the timer applies to control one bit 3
   localparam int CTRL2_ONE_PULSE   = 4;
   localparam int CTRL2_PWM         = 3;
   localparam int CTRL2_CLKSEL_HI   = 3;
   localparam int CTRL2_CLKSEL_LO   = 2;
   localparam int CTRL2_CAP2_EDGE   = 1;
   localparam int CTRL2_EXT_EDGE    = 0;
   // status
   localparam int STAT_CAP1_FLAG    = 7;
   localparam int STAT_OVF_FLAG     = 5;
   localparam int STAT_CAP2_FLAG    = 4;

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [15:0] CNT_RELOAD  = 16'hfffc;
   localparam logic [15:0] CNT_MAX     = 16'hffff;
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [15:0] CAP_RESET   = 16'h0000;
   localparam int          EXT_MIN_GAP = 4;

   typedef enum logic [1:0] {
      FRTC_DIV2,
      FRTC_DIV4,
      FRTC_DIV8,
      FRTC_EXT
   } frtc_clksel_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } frtc_bus_s;

   typedef struct packed {
      logic [15:0] value;
      logic        flag;
      logic        armed;
      logic        inhibit;
   } frtc_cap_s;

endpackage : frtc_pkg

// file: frtc_capture.sv
`timescale 1ns/1ps
// one input capture channel: edge detect, latch, flag and two-step clear
module frtc_capture (
   input  wire logic               i_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_ce,
   input  wire logic               i_pin,
   input  wire logic               i_edge_rise,
   input  wire logic               i_enable,
   input  wire logic [15:0]        i_count,
   input  wire logic               i_stat_rd,
   input  wire logic               i_hi_rd,
   input  wire logic               i_lo_acc,
   input  wire logic               i_lo_rd,
   input  wire logic               i_reload,
   output frtc_pkg::frtc_cap_s     o_cap
);

   typedef struct packed {
      logic                pin_d;
      frtc_pkg::frtc_cap_s cap;
   } frtc_cstate_s;

   frtc_cstate_s st_r;
   frtc_cstate_s st_nxt;
   logic         hit;

   always_comb begin
      st_nxt = st_r;
      hit    = (i_edge_rise ? (i_pin & ~st_r.pin_d) : (~i_pin & st_r.pin_d))
               & i_enable & ~st_r.cap.inhibit;
      st_nxt.pin_d = i_pin;
      if (i_stat_rd && st_r.cap.flag) begin
         st_nxt.cap.armed = 1'b1;
      end
      if (i_lo_acc && st_r.cap.armed) begin
         st_nxt.cap.flag  = 1'b0;
         st_nxt.cap.armed = 1'b0;
      end
      if (i_hi_rd) begin
         st_nxt.cap.inhibit = 1'b1;
      end
      if (i_lo_rd) begin
         st_nxt.cap.inhibit = 1'b0;
      end
      // a capture in the clearing cycle wins over the clear
      if (hit) begin
         st_nxt.cap.value = i_reload ? frtc_pkg::CNT_RELOAD : i_count;
         st_nxt.cap.flag  = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '{pin_d: 1'b1, cap: '{value: frtc_pkg::CAP_RESET, default: 1'b0}};
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   assign o_cap = st_r.cap;

endmodule : frtc_capture

// file: frtc_timer.sv
`timescale 1ns/1ps
module frtc_timer #(
   parameter bit EXT_CLK_BONDED = 1'b1,
   parameter bit CAP1_BONDED    = 1'b1,
   parameter bit CAP2_BONDED    = 1'b1
) (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST_N,
   input  wire logic        i_ce,
   input  wire logic [3:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_cpu_mask,
   input  wire logic        i_halt,
   input  wire logic        i_ext_clock_pin,
   input  wire logic        i_capture_pin_one,
   input  wire logic        i_capture_pin_two,
   output logic [7:0]       o_rdata,
   output logic             o_irq,
   output logic [15:0]      o_count
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  ext_sync;
      logic [1:0]  cap1_sync;
      logic [1:0]  cap2_sync;
      logic [2:0]  presc;
      logic [15:0] count;
      logic [7:0]  lo_buf;
      logic        lo_buf_valid;
      logic        ovf_flag;
      logic        ovf_armed;
      logic [7:0]  ctrl1;
      logic [7:0]  ctrl2;
      logic [7:0]  rdata;
      logic        irq;
      logic [15:0] count_out;
   } frtc_state_s;

   frtc_state_s          st_r;
   frtc_state_s          st_nxt;
   // kept apart from the state struct: it has its own reset and one process may own it
   logic [1:0]           rst_sync_r;
   frtc_pkg::frtc_bus_s  bus;
   frtc_pkg::frtc_cap_s  cap1;
   frtc_pkg::frtc_cap_s  cap2;
   logic                 rst_n_int;
   logic                 tick;
   logic                 ext_edge;
   logic                 wrap;
   logic                 reload;
   logic                 stat_rd;
   logic                 special_mode;
   logic [1:0]           clksel;
   logic                 ext_pin;
   logic                 cap1_pin;
   logic                 cap2_pin;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic hits(input frtc_pkg::frtc_bus_s b, input logic [3:0] off);
      hits = (b.addr == off);
   endfunction : hits

   function automatic logic [7:0] status_byte(input logic c1, input logic ov, input logic c2);
      status_byte = 8'h00;
      status_byte[frtc_pkg::STAT_CAP1_FLAG] = c1;
      status_byte[frtc_pkg::STAT_OVF_FLAG]  = ov;
      status_byte[frtc_pkg::STAT_CAP2_FLAG] = c2;
   endfunction : status_byte

   assign bus       = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
   assign rst_n_int = rst_sync_r[1];

   // unbonded inputs read as one
   assign ext_pin  = EXT_CLK_BONDED ? i_ext_clock_pin   : 1'b1;
   assign cap1_pin = CAP1_BONDED    ? i_capture_pin_one : 1'b1;
   assign cap2_pin = CAP2_BONDED    ? i_capture_pin_two : 1'b1;

   // ------------------------------------------------------------
   // counter clocking
   // ------------------------------------------------------------
   assign clksel  = st_r.ctrl2[frtc_pkg::CTRL2_CLKSEL_HI:frtc_pkg::CTRL2_CLKSEL_LO];
   // only the second and third stages are looked at, never the first
   assign ext_edge = st_r.ctrl2[frtc_pkg::CTRL2_EXT_EDGE]
                     ? (st_r.ext_sync[1] & ~st_r.ext_sync[2])
                     : (~st_r.ext_sync[1] & st_r.ext_sync[2]);

   always_comb begin
      case (frtc_pkg::frtc_clksel_e'(clksel))
         frtc_pkg::FRTC_DIV2: tick = (st_r.presc[0] == 1'b1);
         frtc_pkg::FRTC_DIV4: tick = (st_r.presc[1:0] == 2'h3);
         frtc_pkg::FRTC_DIV8: tick = (st_r.presc == 3'h7);
         frtc_pkg::FRTC_EXT:  tick = ext_edge;
         default:             tick = 1'b0;
      endcase
   end

   // halt freezes counting and the prescaler, but a low byte write still reloads
   assign reload  = bus.wr && (hits(bus, frtc_pkg::OFF_CNT_LO)
                               || hits(bus, frtc_pkg::OFF_ALT_LO));
   assign wrap    = tick && !i_halt && (st_r.count == frtc_pkg::CNT_MAX);
   assign stat_rd = bus.rd && hits(bus, frtc_pkg::OFF_STATUS);
   assign special_mode = st_r.ctrl2[frtc_pkg::CTRL2_ONE_PULSE]
                         | st_r.ctrl1[frtc_pkg::CTRL2_PWM];

   // ------------------------------------------------------------
   // capture channels
   // ------------------------------------------------------------
   frtc_capture u_cap1 (
      .i_clk       (I_CLOCK),
      .i_rst_n     (rst_n_int),
      .i_ce        (i_ce),
      .i_pin       (st_r.cap1_sync[1]),
      .i_edge_rise (st_r.ctrl1[frtc_pkg::CTRL1_CAP1_EDGE]),
      .i_enable    (!special_mode),
      .i_count     (st_r.count),
      .i_stat_rd   (stat_rd),
      .i_hi_rd     (bus.rd && hits(bus, frtc_pkg::OFF_CAP1_HI)),
      .i_lo_acc    ((bus.rd || bus.wr) && hits(bus, frtc_pkg::OFF_CAP1_LO)),
      .i_lo_rd     (bus.rd && hits(bus, frtc_pkg::OFF_CAP1_LO)),
      .i_reload    (reload),
      .o_cap       (cap1)
   );

   frtc_capture u_cap2 (
      .i_clk       (I_CLOCK),
      .i_rst_n     (rst_n_int),
      .i_ce        (i_ce),
      .i_pin       (st_r.cap2_sync[1]),
      .i_edge_rise (st_r.ctrl2[frtc_pkg::CTRL2_CAP2_EDGE]),
      .i_enable    (1'b1),
      .i_count     (st_r.count),
      .i_stat_rd   (stat_rd),
      .i_hi_rd     (bus.rd && hits(bus, frtc_pkg::OFF_CAP2_HI)),
      .i_lo_acc    ((bus.rd || bus.wr) && hits(bus, frtc_pkg::OFF_CAP2_LO)),
      .i_lo_rd     (bus.rd && hits(bus, frtc_pkg::OFF_CAP2_LO)),
      .i_reload    (reload),
      .o_cap       (cap2)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt           = st_r;
      st_nxt.ext_sync  = {st_r.ext_sync[1:0], ext_pin};
      st_nxt.cap1_sync = {st_r.cap1_sync[0], cap1_pin};
      st_nxt.cap2_sync = {st_r.cap2_sync[0], cap2_pin};

      if (!i_halt) begin
         st_nxt.presc = st_r.presc + 3'h1;
      end
      if (reload) begin
         st_nxt.count = frtc_pkg::CNT_RELOAD;
         st_nxt.presc = 3'h0;
      end else if (tick && !i_halt) begin
         st_nxt.count = st_r.count + 16'h0001;
      end

      // overflow flag with two-step clear; a wrap in the clearing cycle wins
      if (stat_rd && st_r.ovf_flag) begin
         st_nxt.ovf_armed = 1'b1;
      end
      if ((bus.rd || bus.wr) && hits(bus, frtc_pkg::OFF_CNT_LO) && st_r.ovf_armed) begin
         st_nxt.ovf_flag  = 1'b0;
         st_nxt.ovf_armed = 1'b0;
      end
      if (wrap) begin
         st_nxt.ovf_flag = 1'b1;
      end

      // control registers
      if (bus.wr && hits(bus, frtc_pkg::OFF_CTRL1)) begin
         st_nxt.ctrl1 = bus.wdata;
      end
      if (bus.wr && hits(bus, frtc_pkg::OFF_CTRL2)) begin
         st_nxt.ctrl2 = bus.wdata;
      end

      // read data and low byte buffering
      st_nxt.rdata = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            frtc_pkg::OFF_CTRL1:   st_nxt.rdata = st_r.ctrl1;
            frtc_pkg::OFF_CTRL2:   st_nxt.rdata = st_r.ctrl2;
            frtc_pkg::OFF_STATUS:  st_nxt.rdata = status_byte(cap1.flag, st_r.ovf_flag,
                                                              cap2.flag);
            frtc_pkg::OFF_CAP1_HI: st_nxt.rdata = cap1.value[15:8];
            frtc_pkg::OFF_CAP1_LO: st_nxt.rdata = cap1.value[7:0];
            frtc_pkg::OFF_CAP2_HI: st_nxt.rdata = cap2.value[15:8];
            frtc_pkg::OFF_CAP2_LO: st_nxt.rdata = cap2.value[7:0];
            frtc_pkg::OFF_CNT_HI, frtc_pkg::OFF_ALT_HI: begin
               st_nxt.rdata = st_r.count[15:8];
               if (!st_r.lo_buf_valid) begin
                  st_nxt.lo_buf       = st_r.count[7:0];
                  st_nxt.lo_buf_valid = 1'b1;
               end
            end
            frtc_pkg::OFF_CNT_LO, frtc_pkg::OFF_ALT_LO: begin
               st_nxt.rdata = st_r.lo_buf_valid ? st_r.lo_buf : st_r.count[7:0];
               st_nxt.lo_buf_valid = 1'b0;
            end
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      // pending request persists while mask or enable blocks it
      st_nxt.irq = !i_cpu_mask
                   && ((st_nxt.ovf_flag && st_nxt.ctrl1[frtc_pkg::CTRL1_OVF_IRQ_EN])
                       || ((cap1.flag || cap2.flag)
                           && st_nxt.ctrl1[frtc_pkg::CTRL1_CAP_IRQ_EN]));
      st_nxt.count_out = st_nxt.count;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   always_ff @(posedge I_CLOCK or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_r.ext_sync     <= 3'h7;
         st_r.cap1_sync    <= 2'h3;
         st_r.cap2_sync    <= 2'h3;
         st_r.presc        <= 3'h0;
         st_r.count        <= frtc_pkg::CNT_RELOAD;
         st_r.lo_buf       <= 8'h00;
         st_r.lo_buf_valid <= 1'b0;
         st_r.ovf_flag     <= 1'b0;
         st_r.ovf_armed    <= 1'b0;
         st_r.ctrl1        <= frtc_pkg::CTRL_RESET;
         st_r.ctrl2        <= frtc_pkg::CTRL_RESET;
         st_r.rdata        <= 8'h00;
         st_r.irq          <= 1'b0;
         st_r.count_out    <= frtc_pkg::CNT_RELOAD;
      end else if (i_ce) begin
         st_r.ext_sync     <= st_nxt.ext_sync;
         st_r.cap1_sync    <= st_nxt.cap1_sync;
         st_r.cap2_sync    <= st_nxt.cap2_sync;
         st_r.presc        <= st_nxt.presc;
         st_r.count        <= st_nxt.count;
         st_r.lo_buf       <= st_nxt.lo_buf;
         st_r.lo_buf_valid <= st_nxt.lo_buf_valid;
         st_r.ovf_flag     <= st_nxt.ovf_flag;
         st_r.ovf_armed    <= st_nxt.ovf_armed;
         st_r.ctrl1        <= st_nxt.ctrl1;
         st_r.ctrl2        <= st_nxt.ctrl2;
         st_r.rdata        <= st_nxt.rdata;
         st_r.irq          <= st_nxt.irq;
         st_r.count_out    <= st_nxt.count_out;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_irq   = st_r.irq;
   assign o_count = st_r.count_out;

endmodule : frtc_timer

// file: frtc_pins_model.sv
`timescale 1ns/1ps
// far side of the timer pins: an external count clock and two capture sources
module frtc_pins_model (
   input  wire logic i_clk,
   input  wire logic i_ext_run,
   input  wire logic i_cap1,
   input  wire logic i_cap2,
   output logic      o_ext_clock_pin,
   output logic      o_capture_pin_one,
   output logic      o_capture_pin_two
);
   logic [1:0] div_r;
   initial begin
      div_r = 2'h0;
      o_ext_clock_pin = 1'b0;
   end
   // a toggle every fourth clock puts like edges eight clocks apart; stands still when stopped
   always @(posedge i_clk) begin
      if (i_ext_run) begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3) begin
            o_ext_clock_pin <= ~o_ext_clock_pin;
         end
      end
   end
   assign o_capture_pin_one = i_cap1;
   assign o_capture_pin_two = i_cap2;
endmodule : frtc_pins_model

// file: frtc_checker_sva.sv
`timescale 1ns/1ps
module frtc_checker (
   input wire logic        I_CLOCK,
   input wire logic        I_RST_N,
   input wire logic        i_ce,
   input wire logic [3:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic        i_cpu_mask,
   input wire logic        i_halt,
   input wire logic        i_ext_clock_pin,
   input wire logic        i_capture_pin_one,
   input wire logic        i_capture_pin_two,
   input wire logic [7:0]  o_rdata,
   input wire logic        o_irq,
   input wire logic [15:0] o_count
);
   logic [7:0] ctrl1_r;
   logic [1:0] clksel_r;
   // shadows of control bits that the ports cannot show
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ctrl1_r <= frtc_pkg::CTRL_RESET;
         clksel_r <= 2'h0;
      end else if (i_ce && i_wr && i_addr == frtc_pkg::OFF_CTRL1) begin
         ctrl1_r <= i_wdata;
      end else if (i_ce && i_wr && i_addr == frtc_pkg::OFF_CTRL2) begin
         clksel_r <= i_wdata[3:2];
      end
   end
   default clocking dc @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);
   a_rdata_idle:
   assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_high_byte:
   assert property (i_rd && (i_addr == frtc_pkg::OFF_CNT_HI || i_addr == frtc_pkg::OFF_ALT_HI)
      |=> o_rdata == $past(o_count[15:8]))
      else $error("high byte read differs from count");
   a_count_reload:
   assert property (i_wr && (i_addr == frtc_pkg::OFF_CNT_LO || i_addr == frtc_pkg::OFF_ALT_LO)
      |-> ##[1:3] o_count == frtc_pkg::CNT_RELOAD)
      else $error("low byte write did not reload count");
   a_count_step:
   assert property ($changed(o_count) |-> o_count == $past(o_count) + 16'h0001
      || o_count == frtc_pkg::CNT_RELOAD)
      else $error("count moved other than by one");
   a_halt_freeze:
   assert property (i_halt && $past(i_halt) && $past(i_halt, 2) && !$past(i_wr)
      && !$past(i_wr, 2) |-> $stable(o_count))
      else $error("count moved in halt");
   // a reload may restart the prescaler, so gaps are only timed from plain ticks
   a_div8_gap:
   assert property ($changed(o_count) && o_count != frtc_pkg::CNT_RELOAD && clksel_r == 2'h2
      && $past(clksel_r) == 2'h2 |=> (!$changed(o_count)
      || o_count == frtc_pkg::CNT_RELOAD || clksel_r != 2'h2)[*7])
      else $error("divide by eight ticked early");
   a_irq_masked:
   assert property ($past(i_cpu_mask) |-> !o_irq)
      else $error("irq raised while masked");
   a_irq_enable:
   assert property (o_irq |-> (($past(ctrl1_r) | ctrl1_r) & 8'ha0) != 8'h00)
      else $error("irq raised with no enable");
   c_hi_read: cover property (i_rd && i_addr == frtc_pkg::OFF_CNT_HI);
   c_irq: cover property ($rose(o_irq));
   c_ext: cover property ($changed(o_count) && clksel_r == 2'h3);
endmodule : frtc_checker

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   typedef struct packed {
      logic [3:0] a;
      logic       w;
      logic [7:0] e;
   } frtc_row_s;
   logic        clk;
   logic        rst_n;
   logic [3:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic        mask;
   logic        halt;
   logic        ext_run;
   logic        cap1;
   logic        cap2;
   logic        ext_pin;
   logic        pin1;
   logic        pin2;
   logic [7:0]  rdata;
   logic        irq;
   logic [15:0] count;
   logic [15:0] delta;
   logic [7:0]  v;
   int          fails;
   int          n_compared;
   frtc_row_s   rows [10];
   logic [7:0]  modes [6] = '{8'h00, 8'h04, 8'h08, 8'h0d, 8'h0c, 8'h0c};
   int          ticks [6] = '{48, 24, 12, 12, 12, 0};
   frtc_timer dut (
      .I_CLOCK(clk), .I_RST_N(rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .i_cpu_mask(mask), .i_halt(halt), .i_ext_clock_pin(ext_pin),
      .i_capture_pin_one(pin1), .i_capture_pin_two(pin2), .o_rdata(rdata), .o_irq(irq),
      .o_count(count)
   );
   frtc_pins_model pins (
      .i_clk(clk), .i_ext_run(ext_run), .i_cap1(cap1), .i_cap2(cap2),
      .o_ext_clock_pin(ext_pin), .o_capture_pin_one(pin1), .o_capture_pin_two(pin2)
   );
   always #2.5 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic final_report;
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      final_report();
   end
   initial begin
      // capture pins idle high, like the synchroniser reset, so reset makes no false edge
      {clk, wr, rd, mask, ext_run, rst_n} = '0;
      {halt, cap1, cap2} = 3'b111;
      addr = '0;
      wdata = '0;
      fails = 0;
      n_compared = 0;
      rows = '{'{frtc_pkg::OFF_CTRL1, 1'b0, 8'h00}, '{frtc_pkg::OFF_CTRL2, 1'b0, 8'h00},
         '{frtc_pkg::OFF_STATUS, 1'b0, 8'h00}, '{frtc_pkg::OFF_CAP1_HI, 1'b1, 8'h00},
         '{frtc_pkg::OFF_CAP1_LO, 1'b0, 8'h00}, '{frtc_pkg::OFF_CAP2_HI, 1'b0, 8'h00},
         '{frtc_pkg::OFF_CAP2_LO, 1'b1, 8'h00}, '{4'h7, 1'b1, 8'h00},
         '{4'hc, 1'b0, 8'h00}, '{4'hf, 1'b1, 8'h00}};
      tick(5);
      `CHK("count_in_reset", frtc_pkg::CNT_RELOAD, count)
      tick(5);
      rst_n <= 1'b1;
      tick(4);
      // halted since reset, so no overflow may show yet
      foreach (rows[i]) begin
         if (rows[i].w) wr_reg(rows[i].a, 8'hff);
         rd_reg(rows[i].a, v);
         `CHK("reg_read", rows[i].e, v)
      end
      wr_reg(frtc_pkg::OFF_CNT_LO, 8'h00);
      tick(20);
      rd_reg(frtc_pkg::OFF_CNT_HI, v);
      `CHK("frozen_hi", 8'hff, v)
      @(posedge clk) halt <= 1'b0;
      tick(30);
      rd_reg(frtc_pkg::OFF_CNT_HI, v);
      rd_reg(frtc_pkg::OFF_CNT_LO, v);
      `CHK("buffered_lo", 8'hfc, v)
      // the low read above came before any status read that saw the flag set, so the flag stays
      rd_reg(frtc_pkg::OFF_STATUS, v);
      `CHK("ovf_set", 1'b1, v[frtc_pkg::STAT_OVF_FLAG])
      rd_reg(frtc_pkg::OFF_ALT_LO, v);
      rd_reg(frtc_pkg::OFF_STATUS, v);
      `CHK("ovf_kept", 1'b1, v[frtc_pkg::STAT_OVF_FLAG])
      @(posedge clk) mask <= 1'b1;
      wr_reg(frtc_pkg::OFF_CTRL1, 8'h20);
      tick(3);
      `CHK("irq_masked", 1'b0, irq)
      @(posedge clk) mask <= 1'b0;
      tick(3);
      `CHK("irq_pending", 1'b1, irq)
      rd_reg(frtc_pkg::OFF_CNT_LO, v);
      rd_reg(frtc_pkg::OFF_STATUS, v);
      `CHK("ovf_clear", 1'b0, v[frtc_pkg::STAT_OVF_FLAG])
      `CHK("irq_gone", 1'b0, irq)
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) halt <= 1'b1;
         wr_reg(frtc_pkg::OFF_CTRL2, modes[i]);
         wr_reg(frtc_pkg::OFF_CNT_LO, 8'h00);
         @(posedge clk) halt <= 1'b0;
         ext_run <= (i == 3 || i == 4);
         tick(96);
         @(posedge clk) halt <= 1'b1;
         ext_run <= 1'b0;
         tick(4);
         delta = count - frtc_pkg::CNT_RELOAD;
         `CHK("ticks", 1'b1, int'(delta) <= ticks[i] + 2 && int'(delta) + 2 >= ticks[i])
      end
      wr_reg(frtc_pkg::OFF_CTRL2, 8'h00);
      wr_reg(frtc_pkg::OFF_CTRL1, 8'h82);
      // falling edge is not the selected one now, so this only prepares a rising edge
      @(posedge clk) cap1 <= 1'b0;
      tick(4);
      wr_reg(frtc_pkg::OFF_CNT_LO, 8'h00);
      @(posedge clk) {cap1, cap2} <= 2'b10;
      tick(8);
      `CHK("cap_irq", 1'b1, irq)
      rd_reg(frtc_pkg::OFF_STATUS, v);
      `CHK("cap_flags", 8'h90, v & 8'h90)
      rd_reg(frtc_pkg::OFF_CAP1_HI, v);
      `CHK("cap1_hi", 8'hff, v)
      rd_reg(frtc_pkg::OFF_CAP1_LO, v);
      `CHK("cap1_lo", 8'hfc, v)
      rd_reg(frtc_pkg::OFF_CAP2_LO, v);
      @(posedge clk) {cap1, cap2} <= 2'b01;
      tick(8);
      `CHK("irq_low", 1'b0, irq)
      rd_reg(frtc_pkg::OFF_CAP2_HI, v);
      @(posedge clk) cap2 <= 1'b0;
      tick(8);
      rd_reg(frtc_pkg::OFF_STATUS, v);
      `CHK("blocked", 8'h00, v & 8'h90)
      rd_reg(frtc_pkg::OFF_CAP2_LO, v);
      @(posedge clk) cap2 <= 1'b1;
      wr_reg(frtc_pkg::OFF_CTRL2, 8'h10);
      @(posedge clk) {cap1, cap2} <= 2'b10;
      tick(8);
      rd_reg(frtc_pkg::OFF_STATUS, v);
      `CHK("pulse_mode", 8'h10, v & 8'h90)
      rd_reg(frtc_pkg::OFF_CAP2_LO, v);
      wr_reg(frtc_pkg::OFF_CTRL2, 8'h00);
      wr_reg(frtc_pkg::OFF_CTRL1, 8'h8a);
      @(posedge clk) cap1 <= 1'b0;
      tick(8);
      @(posedge clk) cap1 <= 1'b1;
      tick(8);
      rd_reg(frtc_pkg::OFF_STATUS, v);
      `CHK("pwm_mode", 8'h00, v & 8'h90)
      final_report();
   end
endmodule : tb_top
bind frtc_timer frtc_checker chk (
   .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_cpu_mask(i_cpu_mask), .i_halt(i_halt),
   .i_ext_clock_pin(i_ext_clock_pin), .i_capture_pin_one(i_capture_pin_one),
   .i_capture_pin_two(i_capture_pin_two), .o_rdata(o_rdata), .o_irq(o_irq), .o_count(o_count)
);
